// file: rtl/cpbp_data_regs.sv
// Purpose: sixteen general data registers with one write and three read ports
// Assumes: write and reads on the same clock; reads are combinational
// Notes:   reads A and B bypass a write in flight, so an operation that starts in the
//          cycle that completes a port read sees the new byte
`timescale 1ns/10ps
module cpbp_data_regs
  import cpbp_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  // write port
  input  wire logic                 wr_en_i,
  input  wire logic [REG_IDX_W-1:0] wr_idx_i,
  input  wire logic [BYTE_W-1:0]    wr_data_i,
  // read ports
  input  wire logic [REG_IDX_W-1:0] rd_a_idx_i,
  output logic      [BYTE_W-1:0]    rd_a_data_o,
  input  wire logic [REG_IDX_W-1:0] rd_b_idx_i,
  output logic      [BYTE_W-1:0]    rd_b_data_o,
  input  wire logic [REG_IDX_W-1:0] rd_c_idx_i,
  output logic      [BYTE_W-1:0]    rd_c_data_o
);

  logic [BYTE_W-1:0] data_reg  [REG_COUNT];
  logic [BYTE_W-1:0] data_next [REG_COUNT];

  // ==========================================================================
  // one flop group per entry
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_entry
    always_comb begin
      data_next[g] = data_reg[g];
      if (wr_en_i && (wr_idx_i == REG_IDX_W'(g))) begin
        data_next[g] = wr_data_i;
      end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
        data_reg[g] <= DATA_REG_RST;
      end else begin
        data_reg[g] <= data_next[g];
      end
    end
  end

  // ==========================================================================
  // reads: A and B bypassed, C not
  assign rd_a_data_o = data_next[rd_a_idx_i];
  assign rd_b_data_o = data_next[rd_b_idx_i];
  assign rd_c_data_o = data_reg[rd_c_idx_i];   // peek shows stored value only

endmodule // cpbp_data_regs

// file: rtl/cpbp_pkg.sv
// Purpose: shared widths, types and reset values of the byte port interface
// Assumes: one clock, asynchronous active-high reset
// Notes:   included by every design file of the block
package cpbp_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned BYTE_W      = 8;   // select, inbound and outbound
  localparam int unsigned REG_COUNT   = 16;  // general data registers
  localparam int unsigned REG_IDX_W   = 4;   // index into data registers

  // ==========================================================================
  // reset values
  localparam logic [7:0] SELECT_RST   = 8'h00;
  localparam logic [7:0] OUT_BYTE_RST = 8'h00;
  localparam logic [7:0] DATA_REG_RST = 8'h00;

  // ==========================================================================
  // types
  typedef enum logic {
    CPBP_OP_READ,
    CPBP_OP_WRITE
  } cpbp_op_e;

  typedef enum logic [1:0] {
    CPBP_IDLE,
    CPBP_FIRST,
    CPBP_SECOND
  } cpbp_state_e;

endpackage

// file: rtl/cpbp_port_if.sv
// Purpose: byte-wide port interface of a small processor core
// Assumes: inbound byte comes from fabric logic on ref_clk_i, no sync needed
// Notes:   each port operation takes exactly two cycles; the next may start
//          in the second cycle of the one before, giving back-to-back issue
//          a direct load that meets a port capture is dropped: the port wins
//          buses keep their last value, so fabric decode must use a strobe
//          to tell a live operation from a stale address
//          peek shows the stored byte only, from the cycle right after the capture edge
`timescale 1ns/10ps
module cpbp_port_if
  import cpbp_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  // operation request from instruction execution
  input  wire logic                 op_valid_i,
  output logic                      op_ready_o,
  input  wire cpbp_pkg::cpbp_op_e   op_kind_i,
  input  wire logic                 op_use_pointer_i,
  input  wire logic [REG_IDX_W-1:0] target_register_i,
  input  wire logic [REG_IDX_W-1:0] pointer_register_i,
  input  wire logic [BYTE_W-1:0]    immediate_addr_i,
  output logic                      op_done_o,
  // direct data register access for execution side
  input  wire logic                 reg_load_i,
  input  wire logic [REG_IDX_W-1:0] reg_load_idx_i,
  input  wire logic [BYTE_W-1:0]    reg_load_data_i,
  input  wire logic [REG_IDX_W-1:0] reg_peek_idx_i,
  output logic      [BYTE_W-1:0]    reg_peek_data_o,
  // port pins toward fabric logic
  output logic      [BYTE_W-1:0]    peripheral_select_o,
  output logic      [BYTE_W-1:0]    out_byte_o,
  input  wire logic [BYTE_W-1:0]    in_byte_i,
  output logic                      read_strobe_o,
  output logic                      write_strobe_o
);

  // ==========================================================================
  // declarations
  cpbp_state_e              state_reg,    state_next;
  cpbp_op_e                 kind_reg,     kind_next;
  logic [REG_IDX_W-1:0]     target_reg,   target_next;
  logic [BYTE_W-1:0]        select_reg,   select_next;
  logic [BYTE_W-1:0]        out_reg,      out_next;
  logic                     rd_stb_reg,   rd_stb_next;
  logic                     wr_stb_reg,   wr_stb_next;

  logic                     accept;
  logic                     capture;
  logic                     rf_wr_en;
  logic [REG_IDX_W-1:0]     rf_wr_idx;
  logic [BYTE_W-1:0]        rf_wr_data;
  logic [BYTE_W-1:0]        pointer_data;
  logic [BYTE_W-1:0]        source_data;
  logic [BYTE_W-1:0]        chosen_select;

  // ==========================================================================
  // data registers
  // pointer and source reads bypass a capture in flight
  cpbp_data_regs u_regs (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .wr_en_i     (rf_wr_en),
    .wr_idx_i    (rf_wr_idx),
    .wr_data_i   (rf_wr_data),
    .rd_a_idx_i  (pointer_register_i),
    .rd_a_data_o (pointer_data),
    .rd_b_idx_i  (target_register_i),
    .rd_b_data_o (source_data),
    .rd_c_idx_i  (reg_peek_idx_i),
    .rd_c_data_o (reg_peek_data_o)
  );

  // ==========================================================================
  // address source
  cpbp_select_src u_sel (
    .use_pointer_i  (op_use_pointer_i),
    .pointer_data_i (pointer_data),
    .immediate_i    (immediate_addr_i),
    .select_o       (chosen_select)
  );

  // ==========================================================================
  // handshake and register write port
  // a new operation may start in idle or in the second cycle of the last one
  assign op_ready_o = (state_reg == CPBP_IDLE) || (state_reg == CPBP_SECOND);
  assign accept     = op_valid_i && op_ready_o;
  assign op_done_o  = (state_reg == CPBP_SECOND);
  // capture at the edge ending the second read cycle
  assign capture    = (state_reg == CPBP_SECOND) && (kind_reg == CPBP_OP_READ);

  // port capture has priority over a direct load in the same cycle
  always_comb begin
    rf_wr_en   = capture || reg_load_i;
    rf_wr_idx  = reg_load_idx_i;
    rf_wr_data = reg_load_data_i;
    if (capture) begin
      rf_wr_idx  = target_reg;
      rf_wr_data = in_byte_i;
    end
  end

  // ==========================================================================
  // sequencer next state
  always_comb begin
    state_next  = state_reg;
    kind_next   = kind_reg;
    target_next = target_reg;
    select_next = select_reg;
    out_next    = out_reg;
    case (state_reg)
      CPBP_IDLE,
      CPBP_SECOND: begin
        state_next = CPBP_IDLE;
        if (accept) begin
          state_next  = CPBP_FIRST;
          kind_next   = op_kind_i;
          target_next = target_register_i;
          select_next = chosen_select;
          if (op_kind_i == CPBP_OP_WRITE) begin
            out_next = source_data;
          end
        end
      end
      CPBP_FIRST: begin
        // select and outbound byte held, never waits on the fabric
        state_next = CPBP_SECOND;
      end
      default: begin
        state_next = CPBP_IDLE;
      end
    endcase
  end

  // strobes registered so they are clean single-cycle pulses
  // taken from the next state so the flop lands them in the second cycle
  always_comb begin
    rd_stb_next = (state_next == CPBP_SECOND) && (kind_next == CPBP_OP_READ);
    wr_stb_next = (state_next == CPBP_SECOND) && (kind_next == CPBP_OP_WRITE);
  end

  // ==========================================================================
  // sequencer registers
  // target index kept so a back-to-back op may change the request pins
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg  <= CPBP_IDLE;
      kind_reg   <= CPBP_OP_READ;
      target_reg <= '0;
      select_reg <= SELECT_RST;
      out_reg    <= OUT_BYTE_RST;
      rd_stb_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      kind_reg   <= kind_next;
      target_reg <= target_next;
      select_reg <= select_next;
      out_reg    <= out_next;
      rd_stb_reg <= rd_stb_next;
      wr_stb_reg <= wr_stb_next;
    end
  end

  // ==========================================================================
  // pin outputs, all from flops; buses keep last value between operations
  assign peripheral_select_o = select_reg;
  assign out_byte_o          = out_reg;
  assign read_strobe_o       = rd_stb_reg;
  assign write_strobe_o      = wr_stb_reg;

  // ==========================================================================
  // assertions
  // internal state is watched too, so a broken sequencer fails close to
  // its cause rather than only at the pins
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  read_strobe_two_a: assert property (
    accept && (op_kind_i == CPBP_OP_READ) |=> !read_strobe_o ##1 read_strobe_o ##1 !read_strobe_o
  ) else $error("read strobe not in second read cycle");

  write_strobe_two_a: assert property (
    accept && (op_kind_i == CPBP_OP_WRITE) |=> !write_strobe_o ##1 write_strobe_o ##1 !write_strobe_o
  ) else $error("write strobe not in second write cycle");

  select_held_a: assert property (
    accept |=> ##1 $stable(peripheral_select_o)
  ) else $error("select changed inside operation");

  out_held_a: assert property (
    accept && (op_kind_i == CPBP_OP_WRITE) |=> ##1 $stable(out_byte_o) && write_strobe_o
  ) else $error("outbound byte not held with write strobe");

  write_source_a: assert property (
    accept && (op_kind_i == CPBP_OP_WRITE) |=> out_byte_o == $past(source_data)
  ) else $error("outbound byte not from chosen register");

  pointer_select_a: assert property (
    accept && op_use_pointer_i |=> peripheral_select_o == $past(pointer_data)
  ) else $error("pointer address not shown in first cycle");

  immediate_select_a: assert property (
    accept && !op_use_pointer_i |=> peripheral_select_o == $past(immediate_addr_i)
  ) else $error("immediate address not shown in first cycle");

  read_capture_a: assert property (
    read_strobe_o |-> rf_wr_en && (rf_wr_data == in_byte_i) && (rf_wr_idx == target_reg)
  ) else $error("inbound byte not written to target register");

  read_lands_a: assert property (
    read_strobe_o ##1 !reg_load_i |-> reg_peek_idx_i != $past(target_reg)
                                      || reg_peek_data_o == $past(in_byte_i)
  ) else $error("target register lacks byte sampled at second edge");

  done_two_a: assert property (
    accept |=> !op_done_o ##1 op_done_o
  ) else $error("operation did not finish in two cycles");

  strobe_excl_a: assert property (
    !(read_strobe_o && write_strobe_o)
  ) else $error("both strobes high");

  strobe_idle_a: assert property (
    (read_strobe_o || write_strobe_o) |-> state_reg == CPBP_SECOND
  ) else $error("strobe outside second cycle");

  // ==========================================================================
  // sequencing: no wait states, ready dropped only in the first cycle
  ready_low_first_a: assert property (
    (state_reg == CPBP_FIRST) |-> !op_ready_o && !op_done_o
  ) else $error("new operation allowed in first cycle");

  first_then_second_a: assert property (
    (state_reg == CPBP_FIRST) |=> (state_reg == CPBP_SECOND)
  ) else $error("operation stalled after first cycle");

  no_stall_a: assert property (
    (state_reg == CPBP_SECOND) && !op_valid_i |=> (state_reg == CPBP_IDLE)
  ) else $error("sequencer did not return to idle");

  // ==========================================================================
  // strobes: single pulses, one per operation, only together with done
  read_pulse_one_a: assert property (
    read_strobe_o |=> !read_strobe_o
  ) else $error("read strobe longer than one cycle");

  write_pulse_one_a: assert property (
    write_strobe_o |=> !write_strobe_o
  ) else $error("write strobe longer than one cycle");

  strobe_done_a: assert property (
    op_done_o == (read_strobe_o || write_strobe_o)
  ) else $error("strobe and done disagree");

  idle_quiet_a: assert property (
    (state_reg == CPBP_IDLE) |-> !read_strobe_o && !write_strobe_o && !op_done_o
  ) else $error("strobe or done while idle");

  // ==========================================================================
  // buses: change only after an accepted operation of the right kind
  select_moves_a: assert property (
    $changed(peripheral_select_o) |-> $past(accept)
  ) else $error("select changed without an operation");

  out_moves_a: assert property (
    $changed(out_byte_o) |-> $past(accept && (op_kind_i == CPBP_OP_WRITE))
  ) else $error("outbound byte changed without a write");

  read_keeps_out_a: assert property (
    accept && (op_kind_i == CPBP_OP_READ) |=> $stable(out_byte_o) ##1 $stable(out_byte_o)
  ) else $error("read operation disturbed outbound byte");

  write_no_load_a: assert property (
    write_strobe_o && !reg_load_i |-> !rf_wr_en
  ) else $error("write operation loaded a data register");

  // ==========================================================================
  // covers
  read_op_c:     cover property (accept && op_kind_i == CPBP_OP_READ ##2 read_strobe_o);
  write_op_c:    cover property (accept && op_kind_i == CPBP_OP_WRITE ##2 write_strobe_o);
  back_to_back_c: cover property (accept ##2 accept ##2 accept);
  pointer_read_c: cover property (accept && op_use_pointer_i && op_kind_i == CPBP_OP_READ);
  broadcast_c:   cover property (write_strobe_o && peripheral_select_o == 8'hFF);

endmodule // cpbp_port_if

// file: rtl/cpbp_select_src.sv
// Purpose: picks the peripheral select byte for a starting port operation
// Assumes: pointer register contents already read from the data registers
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/10ps
module cpbp_select_src
  import cpbp_pkg::*;
(
  // address sources
  input  wire logic              use_pointer_i,
  input  wire logic [BYTE_W-1:0] pointer_data_i,
  input  wire logic [BYTE_W-1:0] immediate_i,
  // chosen address
  output logic      [BYTE_W-1:0] select_o
);

  // ==========================================================================
  // full byte kept: all 256 addresses reachable, no partial decode here
  always_comb begin
    select_o = use_pointer_i ? pointer_data_i : immediate_i;
  end

endmodule // cpbp_select_src

// file: tb/cpbp_fabric_model.sv
// Purpose: fabric-side peripherals seen by the byte port
// Assumes: same clock as the core, one-hot write destinations
// Notes:   one register in the read path; select F0 is a counting fifo
`timescale 1ns/10ps
module cpbp_fabric_model (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // port pins from the core
  input  wire logic [7:0]  peripheral_select_i,
  input  wire logic [7:0]  out_byte_i,
  input  wire logic        read_strobe_i,
  input  wire logic        write_strobe_i,
  output logic      [7:0]  in_byte_o,
  // captured destinations, one byte per one-hot bit
  output logic      [63:0] dest_o
);
  logic [7:0] fifo_cnt;
  logic [7:0] dec_reg;

  // ==========================================================================
  // read side: register mid-path so select-to-inbound is never one long path
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_byte_o <= 8'h00;
      fifo_cnt  <= 8'h00;
    end else begin
      in_byte_o <= (peripheral_select_i == 8'hF0) ? fifo_cnt : peripheral_select_i ^ 8'hA5;
      if (read_strobe_i && peripheral_select_i == 8'hF0) begin
        fifo_cnt <= fifo_cnt + 8'h01;
      end
    end
  end

  // ==========================================================================
  // write side: decode registered in cycle one, qualified by the strobe later
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dec_reg <= 8'h00;
      dest_o  <= 64'h0;
    end else begin
      dec_reg <= peripheral_select_i;
      for (int k = 0; k < 8; k++) begin
        if (write_strobe_i && dec_reg[k]) begin
          dest_o[8*k +: 8] <= out_byte_i;
        end
      end
    end
  end
endmodule // cpbp_fabric_model

// file: tb/tb_top.sv
// Purpose: self-checking bench for the byte port interface
// Assumes: notes queued at acceptance, checked when a strobe shows
// Notes:   register file checked through the peek port at the end
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  import cpbp_pkg::*;
  typedef struct {logic wr; logic [7:0] sel; logic [7:0] dat;} cpbp_note_s;
  logic ref_clk_i = 1'b0, reset_i = 1'b1, op_valid_i = 1'b0, op_use_pointer_i = 1'b0;
  cpbp_op_e op_kind_i = CPBP_OP_READ;
  logic [3:0] target_register_i = 4'h0, pointer_register_i = 4'h0, reg_load_idx_i = 4'h0, reg_peek_idx_i = 4'h0;
  logic [7:0] immediate_addr_i = 8'h00, reg_load_data_i = 8'h00;
  logic reg_load_i = 1'b0, op_ready_o, op_done_o, read_strobe_o, write_strobe_o;
  logic [7:0] reg_peek_data_o, peripheral_select_o, out_byte_o, in_byte_i;
  logic [63:0] dest, mdest = 64'h0;
  logic [7:0] mreg [16];
  logic [7:0] fcnt = 8'h00;
  cpbp_note_s notes [$];
  int err_count = 0, check_count = 0, cycles = 0;

  cpbp_port_if i_cpbp_port_if (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .op_valid_i(op_valid_i),
    .op_ready_o(op_ready_o), .op_kind_i(op_kind_i), .op_use_pointer_i(op_use_pointer_i),
    .target_register_i(target_register_i), .pointer_register_i(pointer_register_i),
    .immediate_addr_i(immediate_addr_i), .op_done_o(op_done_o), .reg_load_i(reg_load_i),
    .reg_load_idx_i(reg_load_idx_i), .reg_load_data_i(reg_load_data_i), .reg_peek_idx_i(reg_peek_idx_i),
    .reg_peek_data_o(reg_peek_data_o), .peripheral_select_o(peripheral_select_o), .out_byte_o(out_byte_o),
    .in_byte_i(in_byte_i), .read_strobe_o(read_strobe_o), .write_strobe_o(write_strobe_o));
  cpbp_fabric_model i_cpbp_fabric_model (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .peripheral_select_i(peripheral_select_o), .out_byte_i(out_byte_o), .read_strobe_i(read_strobe_o),
    .write_strobe_i(write_strobe_o), .in_byte_o(in_byte_i), .dest_o(dest));

  // ==========================================================================
  // clock and hang guard
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // one port operation; valid stays up so the refused cycle one is exercised
  task automatic issue(input cpbp_op_e k, input logic up, input logic [3:0] t, input logic [3:0] p,
                       input logic [7:0] imm);
    cpbp_note_s n;
    logic       rdy;
    n.wr  = (k == CPBP_OP_WRITE);
    n.sel = up ? mreg[p] : imm;
    n.dat = n.wr ? mreg[t] : ((n.sel == 8'hF0) ? fcnt : n.sel ^ 8'hA5);
    if (n.wr) begin
      for (int i = 0; i < 8; i++) if (n.sel[i]) mdest[8*i +: 8] = n.dat;
    end else begin
      mreg[t] = n.dat;
      if (n.sel == 8'hF0) fcnt++;
    end
    op_valid_i         <= 1'b1;
    op_kind_i          <= k;
    op_use_pointer_i   <= up;
    target_register_i  <= t;
    pointer_register_i <= p;
    immediate_addr_i   <= imm;
    do begin
      @(negedge ref_clk_i);
      rdy = op_ready_o;
      @(posedge ref_clk_i);
    end while (rdy !== 1'b1);
    notes.push_back(n);
  endtask

  // ==========================================================================
  // watcher: each strobe retires the oldest note
  always @(posedge ref_clk_i) begin : watch
    cpbp_note_s w;
    if (!reset_i && (read_strobe_o === 1'b1 || write_strobe_o === 1'b1)) begin
      `CHK(read_strobe_o & write_strobe_o, 1'b0)
      `CHK(op_done_o, 1'b1)
      `CHK(op_ready_o, 1'b1)
      if (notes.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        w = notes.pop_front();
        `CHK(write_strobe_o, w.wr)
        `CHK(peripheral_select_o, w.sel)
        if (w.wr) `CHK(out_byte_o, w.dat)
        else `CHK(in_byte_i, w.dat)
      end
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(3228));
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    // random register contents through the direct load path
    for (int i = 0; i < 16; i++) begin
      mreg[i] = 8'($urandom);
      reg_load_i      <= 1'b1;
      reg_load_idx_i  <= 4'(i);
      reg_load_data_i <= mreg[i];
      @(posedge ref_clk_i);
    end
    reg_load_i <= 1'b0;
    // one-hot destinations, then a broadcast reaching all of them
    for (int k = 0; k < 8; k++) issue(CPBP_OP_WRITE, 1'b0, 4'(k), 4'h0, 8'h01 << k);
    issue(CPBP_OP_WRITE, 1'b0, 4'h3, 4'h0, 8'hFF);
    // boundary addresses, fifo pops, pointer taken from a just-read register
    issue(CPBP_OP_READ, 1'b0, 4'h2, 4'h0, 8'h00);
    issue(CPBP_OP_READ, 1'b0, 4'h5, 4'h0, 8'hFF);
    repeat (3) issue(CPBP_OP_READ, 1'b0, 4'h7, 4'h0, 8'hF0);
    issue(CPBP_OP_READ, 1'b1, 4'h9, 4'h7, 8'h00);
    issue(CPBP_OP_WRITE, 1'b0, 4'h9, 4'h0, 8'h0F);
    // random mix with occasional idle cycles
    for (int j = 0; j < 40; j++) begin
      if ($urandom_range(3) == 0) begin
        // two edges so the sequencer really drops back to idle
        op_valid_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
      end
      issue(cpbp_op_e'($urandom_range(1)), 1'($urandom), 4'($urandom), 4'($urandom), 8'($urandom));
    end
    op_valid_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    // stored bytes and captured destinations
    for (int i = 0; i < 16; i++) begin
      reg_peek_idx_i <= 4'(i);
      @(negedge ref_clk_i);
      `CHK(reg_peek_data_o, mreg[i])
      @(posedge ref_clk_i);
    end
    `CHK(dest, mdest)
    `CHK(notes.size(), 0)
    finish_test();
  end
endmodule // tb_top
